// File: hw/dsad_decoder.sv
/*
  Configuration switch decoder with APB register access.
  Latches the eight-position switch bank after reset, derives role,
  location and device addresses, answers address queries, polls subs
  and relays bytes between host and subs while master.
  Assumes switch and carrier pins are asynchronous; all else on clk_in.
*/
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dsad_defines.svh"
module dsad_decoder
  import dsad_pkg::*;
#(
  parameter int POLL_GAP = `DSAD_POLL_GAP_CYC,
  parameter int SETTLE   = `DSAD_SETTLE_CYC
) (
  // Clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Pins
  input  wire logic [7:0]  switch_in,
  input  wire logic        carrier_detect_in,
  // Address query from the I/O side
  input  wire logic        query_valid_in,
  input  wire logic [6:0]  query_addr_in,
  output logic             sel_left_out,
  output logic             sel_right_out,
  // Decoded configuration
  output logic             role_master_out,
  output logic             cfg_latched_out,
  output logic [6:0]       left_addr_out,
  output logic [6:0]       right_addr_out,
  output logic [14:0]      location_out,
  output logic             loc_valid_out,
  output logic             link_modem_out,
  // Polling
  output logic             poll_strobe_out,
  output logic [6:0]       poll_addr_out,
  // Byte relay
  input  wire dsad_byte_s  host_rx_in,
  input  wire dsad_byte_s  sub_rx_in,
  output dsad_byte_s       host_tx_out,
  output dsad_byte_s       sub_tx_out
);
  localparam int GAP_W = $clog2(POLL_GAP + 1);
  localparam int SET_W = $clog2(SETTLE + 1);
  localparam int MOD_W = $clog2(`DSAD_MODEM_CYC + 1);

  if (POLL_GAP < 1) begin : g_bad_gap
    $error("POLL_GAP must be at least one cycle");
  end
  if (SETTLE < 2) begin : g_bad_settle
    $error("SETTLE must cover the synchroniser depth");
  end

  // Sum of the weights of the switches that are on
  function automatic logic [6:0] weight_sum(input logic [6:0] sw);
    logic [6:0] acc;
    acc = 7'h00;
    for (int i = 0; i < 7; i++) begin
      if (sw[i]) begin
        acc = acc + 7'(1 << i);
      end
    end
    return acc;
  endfunction

  // Address match, used by the query port
  function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] b);
    return a == b;
  endfunction

  // Synchronised pins
  logic [7:0] sw_sync;
  logic       carrier_sync;

  dsad_sync #(
    .WIDTH (9)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .async_in ({carrier_detect_in, switch_in}),
    .sync_out ({carrier_sync, sw_sync})
  );

  // State
  logic [SET_W-1:0] settle_ff;
  logic             latched_ff;
  dsad_role_e       role_ff;
  logic [6:0]       sw_val_ff;
  logic             odd_sw_ff;
  dsad_addr_s       addr_ff;
  logic [14:0]      stored_loc_ff;
  logic             loc_err_ff;
  logic [14:0]      eff_loc_ff;
  logic             loc_valid_ff;
  logic [MOD_W-1:0] modem_cnt_ff;
  logic             modem_ff;
  logic             poll_en_ff;
  logic [6:0]       poll_max_ff;
  dsad_poll_e       poll_st_ff;
  logic [GAP_W-1:0] gap_ff;
  logic             strobe_ff;
  logic [6:0]       poll_addr_ff;
  logic             sel_l_ff;
  logic             sel_r_ff;
  dsad_byte_s       host_tx_ff;
  dsad_byte_s       sub_tx_ff;
  logic [31:0]      prdata_ff;
  logic             pready_ff;
  logic             pslverr_ff;

  logic       apb_acc;
  logic       apb_wr;
  logic [6:0] nxt_sw_val;
  logic [14:0] nxt_loc;
  logic [6:0] nxt_poll_addr;

  assign apb_acc    = psel_in && penable_in && !pready_ff;
  assign apb_wr     = apb_acc && pwrite_in;
  assign nxt_sw_val = weight_sum(sw_sync[6:0]);

  // Wait out the synchroniser, then take the switches exactly once
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      settle_ff  <= '0;
      latched_ff <= 1'b0;
    end else if (ce_in && !latched_ff) begin
      if (settle_ff == SET_W'(SETTLE)) begin
        latched_ff <= 1'b1;
      end else begin
        settle_ff <= settle_ff + SET_W'(1);
      end
    end
  end

  // Switch snapshot; later changes are ignored until the next reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      role_ff   <= DSAD_ROLE_SUB;
      sw_val_ff <= 7'h00;
      odd_sw_ff <= 1'b0;
      addr_ff   <= '0;
    end else if (ce_in && !latched_ff && settle_ff == SET_W'(SETTLE)) begin
      role_ff   <= sw_sync[7] ? DSAD_ROLE_MASTER : DSAD_ROLE_SUB;
      sw_val_ff <= nxt_sw_val;
      if (sw_sync[7]) begin
        addr_ff.left  <= `DSAD_MASTER_LEFT;
        addr_ff.right <= `DSAD_MASTER_RIGHT;
        odd_sw_ff     <= 1'b0;
      end else begin
        // Switch one is dropped on a sub so the pair stays even/odd
        addr_ff.left  <= {nxt_sw_val[6:1], 1'b0};
        addr_ff.right <= {nxt_sw_val[6:1], 1'b1};
        odd_sw_ff     <= nxt_sw_val[0];
      end
    end
  end

  // Stored location, written by the location set command
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stored_loc_ff <= `DSAD_LOC_RST;
      loc_err_ff    <= 1'b0;
    end else if (ce_in && apb_wr) begin
      if (paddr_in == `DSAD_OFF_LOCATION) begin
        // Out-of-range values are refused and flagged
        if (pwdata_in[31:15] == 17'h00000 &&
            pwdata_in[14:0] >= `DSAD_LOC_MIN &&
            pwdata_in[14:0] <= `DSAD_LOC_MAX) begin
          stored_loc_ff <= pwdata_in[14:0];
          loc_err_ff    <= 1'b0;
        end else begin
          loc_err_ff <= 1'b1;
        end
      end
    end
  end

  // Effective location: switches, or the stored value when all off
  always_comb begin
    if (sw_val_ff == 7'h00) begin
      nxt_loc = stored_loc_ff;
    end else begin
      nxt_loc = {8'h00, sw_val_ff};
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      eff_loc_ff   <= 15'h0000;
      loc_valid_ff <= 1'b0;
    end else if (ce_in) begin
      if (latched_ff && role_ff == DSAD_ROLE_MASTER) begin
        eff_loc_ff   <= nxt_loc;
        loc_valid_ff <= nxt_loc >= `DSAD_LOC_MIN && nxt_loc <= `DSAD_LOC_MAX;
      end else begin
        eff_loc_ff   <= 15'h0000;
        loc_valid_ff <= 1'b0;
      end
    end
  end

  // Host link kind: a carrier held steady marks a modem, else direct
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      modem_cnt_ff <= '0;
      modem_ff     <= 1'b0;
    end else if (ce_in) begin
      if (!carrier_sync || role_ff != DSAD_ROLE_MASTER) begin
        modem_cnt_ff <= '0;
        modem_ff     <= 1'b0;
      end else if (modem_cnt_ff == MOD_W'(`DSAD_MODEM_CYC)) begin
        modem_ff <= 1'b1;
      end else begin
        modem_cnt_ff <= modem_cnt_ff + MOD_W'(1);
      end
    end
  end

  // Poll control register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      poll_en_ff  <= 1'b0;
      poll_max_ff <= `DSAD_POLLMAX_RST;
    end else if (ce_in && apb_wr && paddr_in == `DSAD_OFF_POLLCTL) begin
      poll_en_ff <= pwdata_in[`DSAD_PC_EN];
      if (pwdata_in[`DSAD_PC_MAX_LSB +: 7] > `DSAD_SUB_MAX) begin
        poll_max_ff <= `DSAD_SUB_MAX;
      end else begin
        poll_max_ff <= {pwdata_in[`DSAD_PC_MAX_LSB + 1 +: 6], 1'b0};
      end
    end
  end

  // Next sub to poll: even addresses from the first sub up to the limit
  always_comb begin
    if (poll_addr_ff >= poll_max_ff || poll_max_ff < `DSAD_FIRST_SUB) begin
      nxt_poll_addr = `DSAD_FIRST_SUB;
    end else begin
      nxt_poll_addr = poll_addr_ff + 7'h02;
    end
  end

  // Poll sequencer; runs only on a latched master with polling on
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      poll_st_ff   <= DSAD_POLL_IDLE;
      gap_ff       <= '0;
      strobe_ff    <= 1'b0;
      poll_addr_ff <= `DSAD_FIRST_SUB;
    end else if (ce_in) begin
      strobe_ff <= 1'b0;
      case (poll_st_ff)
        DSAD_POLL_IDLE: begin
          gap_ff <= '0;
          if (latched_ff && role_ff == DSAD_ROLE_MASTER && poll_en_ff) begin
            poll_st_ff <= DSAD_POLL_WAIT;
          end
        end
        DSAD_POLL_WAIT: begin
          if (!poll_en_ff) begin
            poll_st_ff <= DSAD_POLL_IDLE;
          end else if (gap_ff == GAP_W'(POLL_GAP - 1)) begin
            poll_st_ff <= DSAD_POLL_ISSUE;
          end else begin
            gap_ff <= gap_ff + GAP_W'(1);
          end
        end
        DSAD_POLL_ISSUE: begin
          strobe_ff    <= 1'b1;
          poll_addr_ff <= nxt_poll_addr;
          gap_ff       <= '0;
          poll_st_ff   <= DSAD_POLL_WAIT;
        end
        default: begin
          poll_st_ff <= DSAD_POLL_IDLE;
        end
      endcase
    end
  end

  // Query port: left half answers even address, right half the odd one
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sel_l_ff <= 1'b0;
      sel_r_ff <= 1'b0;
    end else if (ce_in) begin
      sel_l_ff <= query_valid_in && latched_ff &&
                  addr_hit(query_addr_in, addr_ff.left);
      sel_r_ff <= query_valid_in && latched_ff &&
                  addr_hit(query_addr_in, addr_ff.right);
    end
  end

  // Byte relay while master; a modem link drops bytes in both directions without carrier
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      host_tx_ff <= '0;
      sub_tx_ff  <= '0;
    end else if (ce_in) begin
      host_tx_ff.valid <= 1'b0;
      sub_tx_ff.valid  <= 1'b0;
      if (latched_ff && role_ff == DSAD_ROLE_MASTER) begin
        if (host_rx_in.valid && (!modem_ff || carrier_sync)) begin
          sub_tx_ff <= host_rx_in;
        end
        if (sub_rx_in.valid && (!modem_ff || carrier_sync)) begin
          host_tx_ff <= sub_rx_in;
        end
      end
    end
  end

  // APB read mux and answer: one wait state, unmapped addresses error
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (ce_in) begin
      pready_ff  <= apb_acc;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
      if (apb_acc) begin
        if (paddr_in == `DSAD_OFF_STATUS) begin
          prdata_ff[`DSAD_ST_ROLE]           <= role_ff == DSAD_ROLE_MASTER;
          prdata_ff[`DSAD_ST_LATCHED]        <= latched_ff;
          prdata_ff[`DSAD_ST_MODEM]          <= modem_ff;
          prdata_ff[`DSAD_ST_LOCVALID]       <= loc_valid_ff;
          prdata_ff[`DSAD_ST_ODDSW]          <= odd_sw_ff;
          prdata_ff[`DSAD_ST_LOCERR]         <= loc_err_ff;
          prdata_ff[`DSAD_ST_SW_LSB +: 7]    <= sw_val_ff;
          prdata_ff[`DSAD_ST_LEFT_LSB +: 7]  <= addr_ff.left;
          prdata_ff[`DSAD_ST_RIGHT_LSB +: 7] <= addr_ff.right;
        end else if (paddr_in == `DSAD_OFF_LOCATION) begin
          prdata_ff[14:0] <= stored_loc_ff;
        end else if (paddr_in == `DSAD_OFF_EFFLOC) begin
          prdata_ff[14:0] <= eff_loc_ff;
        end else if (paddr_in == `DSAD_OFF_POLLCTL) begin
          prdata_ff[`DSAD_PC_EN]             <= poll_en_ff;
          prdata_ff[`DSAD_PC_MAX_LSB +: 7]   <= poll_max_ff;
        end else if (paddr_in == `DSAD_OFF_POLLSTAT) begin
          prdata_ff[6:0] <= poll_addr_ff;
        end else begin
          pslverr_ff <= 1'b1;
        end
      end
    end
  end

  // Outputs straight from flops
  assign prdata_out      = prdata_ff;
  assign pready_out      = pready_ff;
  assign pslverr_out     = pslverr_ff;
  assign sel_left_out    = sel_l_ff;
  assign sel_right_out   = sel_r_ff;
  assign role_master_out = role_ff == DSAD_ROLE_MASTER;
  assign cfg_latched_out = latched_ff;
  assign left_addr_out   = addr_ff.left;
  assign right_addr_out  = addr_ff.right;
  assign location_out    = eff_loc_ff;
  assign loc_valid_out   = loc_valid_ff;
  assign link_modem_out  = modem_ff;
  assign poll_strobe_out = strobe_ff;
  assign poll_addr_out   = poll_addr_ff;
  assign host_tx_out     = host_tx_ff;
  assign sub_tx_out      = sub_tx_ff;
endmodule
`default_nettype wire

// File: hw/dsad_defines.svh
/*
  Constants of the configuration switch decoder: register offsets,
  field positions, reset values and timing counts.
  Assumes a 200 MHz clock and an APB slave with 32-bit data.
*/
// How it works
// - Switch eight picks the role: on is master, off is sub.
// - Switches one to seven give location (master) or device address (sub).
// - Switch weights are 1,2,4,...,64; value is the sum of switches on.
// - A master takes device addresses zero and one.
// - Master location number is valid from 1 to 32000.
// - Master with switches one to seven off uses the stored location.
// - Sub: switch value is the even left address, right is next odd.
// - Sub addresses stay within 0 to 126, switch setting even.
// - Left half answers the even address, right half the odd one.
// - Switch changes count only after a power cycle.
// - Master polls subs and relays data between them and the host.
// - Master detects modem or direct host link and acts on it.
`ifndef DSAD_DEFINES_SVH
`define DSAD_DEFINES_SVH

// Register byte offsets
`define DSAD_OFF_STATUS    12'h000
`define DSAD_OFF_LOCATION  12'h004
`define DSAD_OFF_EFFLOC    12'h008
`define DSAD_OFF_POLLCTL   12'h00c
`define DSAD_OFF_POLLSTAT  12'h010

// Status fields
`define DSAD_ST_ROLE       0
`define DSAD_ST_LATCHED    1
`define DSAD_ST_MODEM      2
`define DSAD_ST_LOCVALID   3
`define DSAD_ST_ODDSW      4
`define DSAD_ST_LOCERR     5
`define DSAD_ST_SW_LSB     8
`define DSAD_ST_LEFT_LSB   16
`define DSAD_ST_RIGHT_LSB  24

// Poll control fields
`define DSAD_PC_EN         0
`define DSAD_PC_MAX_LSB    8

// Value limits and reset values
`define DSAD_LOC_MIN       15'h0001
`define DSAD_LOC_MAX       15'h7d00
`define DSAD_SUB_MAX       7'h7e
`define DSAD_LOC_RST       15'h0001
`define DSAD_POLLMAX_RST   7'h7e
`define DSAD_MASTER_LEFT   7'h00
`define DSAD_MASTER_RIGHT  7'h01
`define DSAD_FIRST_SUB     7'h02

// Timing
`define DSAD_CLK_NS        5
`define DSAD_SETTLE_CYC    4
`define DSAD_POLL_GAP_NS   1000
`define DSAD_POLL_GAP_CYC  (`DSAD_POLL_GAP_NS / `DSAD_CLK_NS)
`define DSAD_MODEM_NS      500
`define DSAD_MODEM_CYC     ((`DSAD_MODEM_NS + `DSAD_CLK_NS - 1) / `DSAD_CLK_NS)

`endif

// File: hw/dsad_pkg.sv
/*
  Types shared by the configuration switch decoder.
  Assumes nothing beyond the constants header.
*/
package dsad_pkg;
  typedef enum logic {
    DSAD_ROLE_SUB,
    DSAD_ROLE_MASTER
  } dsad_role_e;

  typedef enum logic [1:0] {
    DSAD_POLL_IDLE,
    DSAD_POLL_WAIT,
    DSAD_POLL_ISSUE
  } dsad_poll_e;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } dsad_byte_s;

  typedef struct packed {
    logic [6:0] left;
    logic [6:0] right;
  } dsad_addr_s;
endpackage

// File: hw/dsad_sync.sv
/*
  Two-stage synchroniser for a group of pin levels.
  Assumes the inputs are levels from outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dsad_sync #(
  parameter int WIDTH = 1
) (
  // Clock, reset, enable
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  if (WIDTH < 1) begin : g_bad_width
    $error("dsad_sync width must be at least one");
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce_in) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule
`default_nettype wire

// File: tb/dsad_decoder_chk.sv
/*
  Port checker for the configuration switch decoder.
  Assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dsad_decoder_chk
  import dsad_pkg::*;
(
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        ce_in,
  // APB handshake
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pready_out,
  // Address query
  input wire logic        query_valid_in,
  input wire logic [6:0]  query_addr_in,
  input wire logic        sel_left_out,
  input wire logic        sel_right_out,
  // Decoded configuration
  input wire logic        role_master_out,
  input wire logic        cfg_latched_out,
  input wire logic [6:0]  left_addr_out,
  input wire logic [6:0]  right_addr_out,
  input wire logic [14:0] location_out,
  input wire logic        loc_valid_out,
  input wire logic        link_modem_out,
  // Relay
  input wire dsad_byte_s  host_rx_in,
  input wire dsad_byte_s  sub_tx_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // First access-phase edge, then one wait state and a one-cycle ready
  sequence s_access_start;
    ce_in && psel_in && $rose(penable_in);
  endsequence
  sequence s_answer;
    pready_out ##1 !pready_out;
  endsequence

  a_apb_wait: assert property (s_access_start |=> s_answer)
    else $error("ready not one cycle after access");
  a_master_addrs: assert property (
    cfg_latched_out && role_master_out |-> left_addr_out == 7'h00 && right_addr_out == 7'h01)
    else $error("master addresses wrong");
  a_sub_pair: assert property (
    cfg_latched_out && !role_master_out |-> !left_addr_out[0]
      && right_addr_out == (left_addr_out | 7'h01) && location_out == 15'h0000)
    else $error("sub address pair wrong");
  // Late switch changes must not reach the decoded values
  a_cfg_hold: assert property (
    cfg_latched_out && $past(cfg_latched_out) |-> $stable(role_master_out)
      && $stable(left_addr_out) && $stable(right_addr_out))
    else $error("configuration moved after latch");
  a_query_left: assert property (
    ce_in && query_valid_in && cfg_latched_out && query_addr_in == left_addr_out
      |=> sel_left_out && !sel_right_out)
    else $error("left half missed its address");
  a_query_right: assert property (
    ce_in && query_valid_in && cfg_latched_out && query_addr_in == right_addr_out
      |=> sel_right_out && !sel_left_out)
    else $error("right half missed its address");
  a_query_idle: assert property (
    ce_in && !query_valid_in |=> !sel_left_out && !sel_right_out)
    else $error("select without query");
  a_loc_range: assert property (
    loc_valid_out |-> role_master_out && location_out >= 15'h0001 && location_out <= 15'h7d00)
    else $error("location flagged valid out of range");
  a_relay_host: assert property (
    ce_in && host_rx_in.valid && cfg_latched_out && role_master_out && !link_modem_out
      |=> sub_tx_out.valid && sub_tx_out.data == $past(host_rx_in.data))
    else $error("host byte not relayed");
  a_sub_silent: assert property (!role_master_out |=> !sub_tx_out.valid)
    else $error("sub relayed a byte");
  a_modem_sub: assert property (!role_master_out |-> !link_modem_out)
    else $error("modem flag in sub role");
endmodule
`default_nettype wire

// File: tb/dsad_switch_bank.sv
/*
  Installer's eight-position switch bank.
  Assumes settings may change at any time, also while the controller is running.
*/
`timescale 1ns/1ps
`default_nettype none
module dsad_switch_bank (
  // Positions chosen by the installer, bit 7 is the role switch
  input  wire logic [7:0] setting_in,
  // Contact levels seen by the controller
  output logic      [7:0] switch_out
);
  // A sub uses only even settings, so switch one stays off there
  assign switch_out = {setting_in[7:1], setting_in[0] & setting_in[7]};
endmodule
`default_nettype wire

// File: tb/dip_switch_address_decoder_bench.sv
/*
  Bench for the switch decoder: a table of switch settings, then stored
  location, relay, polling, modem detection and late switch changes.
  Assumes the package, design, switch bank and checker compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module dip_switch_address_decoder_bench
  import dsad_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1, ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, qv = 1'b0, carrier = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, sel_l, sel_r, master, latched, locv, modem, strobe;
  logic [7:0]  setting = 8'h00, sw, s;
  logic [6:0]  qa = 7'h00, left, right, poll_addr, el, erx;
  logic [14:0] loc;
  dsad_byte_s  hrx = '0, srx = '0, htx, stx;
  int          fail_count = 0, checks = 0, n;
  localparam int NR = 13;
  // Switch setting beside the location it should give, zero for a sub
  localparam logic [22:0] ROWS [NR] = '{
    {8'h81, 15'h0001}, {8'h82, 15'h0002}, {8'h84, 15'h0004}, {8'h88, 15'h0008},
    {8'h90, 15'h0010}, {8'ha0, 15'h0020}, {8'hc1, 15'h0041}, {8'hff, 15'h007f},
    {8'h80, 15'h0001}, {8'h0a, 15'h0000}, {8'h42, 15'h0000}, {8'h7e, 15'h0000},
    {8'h00, 15'h0000}};

  always #2.5 clk_in = ~clk_in;

  dsad_switch_bank u_bank (.setting_in(setting), .switch_out(sw));
  // Short poll gap keeps the run brief
  dsad_decoder #(.POLL_GAP(3), .SETTLE(4)) uut (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .switch_in(sw), .carrier_detect_in(carrier),
    .query_valid_in(qv), .query_addr_in(qa), .sel_left_out(sel_l), .sel_right_out(sel_r),
    .role_master_out(master), .cfg_latched_out(latched), .left_addr_out(left),
    .right_addr_out(right), .location_out(loc), .loc_valid_out(locv),
    .link_modem_out(modem), .poll_strobe_out(strobe), .poll_addr_out(poll_addr),
    .host_rx_in(hrx), .sub_rx_in(srx), .host_tx_out(htx), .sub_tx_out(stx));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Counts: %0d checks, %0d mismatches", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    fail_count++;
    $display("[FAIL] %0t %s timed out", $time, what);
    summarize();
  endtask

  // Power cycle with a new setting; switches are read only here
  task automatic power_up(input logic [7:0] v);
    setting <= v;
    rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    n = 0;
    while (latched !== 1'b1 && n < 30) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 30) timeout("latch");
    @(posedge clk_in);
  endtask

  // One APB transfer, waiting for ready; a spare edge before the next setup
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) timeout("apb");
    @(posedge clk_in);
  endtask

  task automatic query(input logic [6:0] a, input logic wl, input logic wr);
    qv <= 1'b1;
    qa <= a;
    @(posedge clk_in);
    qv <= 1'b0;
    @(posedge clk_in);
    check({sel_l, sel_r}, {wl, wr}, "query");
  endtask

  initial begin
    @(posedge clk_in);
    // Table of settings, one power cycle per row
    for (int i = 0; i < NR; i++) begin
      s = ROWS[i][22:15];
      el = s[7] ? 7'h00 : s[6:0];
      erx = s[7] ? 7'h01 : (s[6:0] | 7'h01);
      power_up(s);
      check(master, s[7], "role");
      check({left, right}, {el, erx}, "addresses");
      check(loc, ROWS[i][14:0], "location");
      apb(1'b0, 12'h000, 32'h0);
      check(rd[30:16], {erx, 1'b0, el}, "status");
      query(el, 1'b1, 1'b0);
      query(erx, 1'b0, 1'b1);
      $display("row %0d done", i);
    end
    // Stored location, refused and boundary writes, unmapped place
    power_up(8'h80);
    apb(1'b1, 12'h004, 32'h0000_1388);
    apb(1'b0, 12'h008, 32'h0);
    check({rd[14:0], loc}, {15'h1388, 15'h1388}, "stored location");
    apb(1'b1, 12'h004, 32'h0000_7d01);
    apb(1'b0, 12'h000, 32'h0);
    check({rd[5], loc}, {1'b1, 15'h1388}, "refused location");
    apb(1'b1, 12'h004, 32'h0000_7d00);
    apb(1'b0, 12'h000, 32'h0);
    check({rd[5], loc, locv}, {1'b0, 15'h7d00, 1'b1}, "top location");
    apb(1'b0, 12'h014, 32'h0);
    check({er, rd[30:0]}, 32'h8000_0000, "unmapped");
    $display("stored location test done");
    // Relay both ways while master on a direct link
    hrx <= '{1'b1, 8'ha5};
    @(posedge clk_in);
    hrx <= '0;
    srx <= '{1'b1, 8'h3c};
    @(posedge clk_in);
    srx <= '0;
    check({stx.valid, stx.data}, 9'h1a5, "to sub");
    @(posedge clk_in);
    check({htx.valid, htx.data}, 9'h13c, "to host");
    // Polling up to sub address six
    apb(1'b1, 12'h00c, 32'h0000_0601);
    n = 0;
    // Each strobe moves the address to the next even sub, wrapping above six
    el = 7'h02;
    repeat (40) begin
      @(posedge clk_in);
      if (strobe === 1'b1) begin
        n++;
        el = (el >= 7'h06) ? 7'h02 : el + 7'h02;
        check(poll_addr, el, "poll");
      end
    end
    check(32'(n >= 9), 32'h1, "poll rate");
    // A limit above the top sub address is clamped to it
    apb(1'b1, 12'h00c, 32'h0000_7f01);
    apb(1'b0, 12'h00c, 32'h0);
    check(rd, 32'h0000_7e01, "poll limit clamp");
    $display("relay and poll test done");
    // Carrier held long enough marks a modem link, its loss clears it
    carrier <= 1'b1;
    repeat (110) @(posedge clk_in);
    check(modem, 1'b1, "modem");
    carrier <= 1'b0;
    repeat (10) @(posedge clk_in);
    check(modem, 1'b0, "direct");
    $display("modem test done");
    // Switches moved while running are ignored; a sub relays nothing
    power_up(8'h0a);
    setting <= 8'h86;
    hrx <= '{1'b1, 8'h55};
    @(posedge clk_in);
    hrx <= '0;
    @(posedge clk_in);
    check(stx.valid, 1'b0, "sub relay");
    // Enable low freezes the block, so a matching query is not taken
    ce <= 1'b0;
    qv <= 1'b1;
    qa <= 7'h0a;
    @(posedge clk_in);
    qv <= 1'b0;
    @(posedge clk_in);
    check({sel_l, sel_r}, 2'b00, "frozen query");
    ce <= 1'b1;
    repeat (20) @(posedge clk_in);
    check({master, left}, {1'b0, 7'h0a}, "late change");
    $display("late change test done");
    summarize();
  end
endmodule

bind dsad_decoder dsad_decoder_chk u_chk (
  .clk_in, .rst_in, .ce_in, .psel_in, .penable_in, .pready_out, .query_valid_in,
  .query_addr_in, .sel_left_out, .sel_right_out, .role_master_out, .cfg_latched_out,
  .left_addr_out, .right_addr_out, .location_out, .loc_valid_out, .link_modem_out,
  .host_rx_in, .sub_tx_out);
`default_nettype wire
